/* common/enclave_exit_pkg.sv */
// Purpose: Shared constants and carriers for the enclave guest exit control block
// Assumes: Register port with one-cycle read latency, 32-bit data
// Notes:   Offsets are word-aligned byte addresses
package enclave_exit_pkg;
   // Register map (byte addresses)
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_BITMAP_LO = 8'h04;
   localparam logic [7:0] OFS_BITMAP_HI = 8'h08;
   localparam logic [7:0] OFS_SEC_CTRL  = 8'h0C;
   localparam logic [7:0] OFS_QUAL_LO   = 8'h10;
   localparam logic [7:0] OFS_QUAL_HI   = 8'h14;
   localparam logic [7:0] OFS_REASON    = 8'h18;
   localparam logic [7:0] OFS_STATUS    = 8'h1C;
   // Field positions
   localparam int CTRL_EXIT_EN_BIT   = 0;
   localparam int CTRL_APIC_VIRT_BIT = 1;
   localparam int SEC_VIRT_EXT_BIT   = 29;
   // Reset values
   localparam logic [63:0] BITMAP_RESET = 64'h0000_0000_0000_0000;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   // Exit reasons
   localparam logic [15:0] REASON_NONE     = 16'h0000;
   localparam logic [15:0] REASON_CONFLICT = 16'h0047;
   localparam logic [15:0] REASON_LEAF     = 16'h003C;
   localparam logic [15:0] REASON_APIC     = 16'h002C;
   // Conflict qualification codes
   localparam logic [15:0] QC_TRACK_RES  = 16'h0000;
   localparam logic [15:0] QC_TRACK_REF  = 16'h0001;
   localparam logic [15:0] QC_PAGE_FAULT = 16'h0002;
   localparam logic [15:0] QC_PAGE_ERR   = 16'h0003;
   // Fault vectors
   localparam logic [7:0] VEC_NONE = 8'h00;
   localparam logic [7:0] VEC_GP   = 8'h0D;
   localparam logic [7:0] VEC_PF   = 8'h0E;

   typedef enum logic [1:0] {
      CONF_TRACK_RES = 2'h0,
      CONF_TRACK_REF = 2'h1,
      CONF_PAGE_FAULT = 2'h2,
      CONF_PAGE_ERR  = 2'h3
   } conflict_kind_t;

   typedef enum logic [1:0] {
      ACC_EXPLICIT_ENCL = 2'h0,
      ACC_IMPLICIT      = 2'h1,
      ACC_NON_ENCLAVE   = 2'h3
   } access_kind_t;

   typedef enum logic [1:0] {
      TGT_ENCLAVE_CONTROL = 2'h0,
      TGT_THREAD_CONTROL  = 2'h1,
      TGT_STATE_SAVE      = 2'h2,
      TGT_OTHER           = 2'h3
   } implicit_target_t;

   // Privileged or user leaf request from the decoder
   typedef struct packed {
      logic       valid;
      logic       guest;
      logic       legal_mode;
      logic       user_leaf;
      logic [1:0] current_privilege_level;
      logic [5:0] leaf;
   } leaf_req_t;

   typedef struct packed {
      logic       allow;
      logic       vm_exit;
      logic       fault_gp;
      logic       fault_ud;
   } leaf_rsp_t;

   // Memory access classification request
   typedef struct packed {
      logic             valid;
      logic             guest;
      access_kind_t     kind;
      implicit_target_t target;
      logic             apic_overlap;
      logic             fetch;
      logic             in_enclave;
      logic             in_range;
      logic             xlat_ok;
      logic             page_store;
   } mem_req_t;

   typedef struct packed {
      logic       allow;
      logic       apic_exit;
      logic       redirect;
      logic [7:0] fault_vec;
      logic       set_ad;
      logic       nested_walk;
   } mem_rsp_t;

   typedef struct packed {
      logic           valid;
      logic           guest;
      conflict_kind_t kind;
      logic [15:0]    err;
   } conflict_req_t;
endpackage

/* verilog/enclave_guest_exit_control.sv */
// Purpose: Guest exit decisions for enclave instructions and enclave memory accesses
// Assumes: All request inputs are synchronous to sys_clk_i
// Notes:   Decisions are registered; answers stand one cycle after the request
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
module enclave_guest_exit_control (
   // Clock and reset
   input  wire logic                            sys_clk_i,
   input  wire logic                            reset_i,
   // Register port
   input  wire logic [7:0]                      reg_addr_i,
   input  wire logic [31:0]                     reg_wdata_i,
   input  wire logic                            reg_wr_i,
   input  wire logic                            reg_rd_i,
   output logic      [31:0]                     reg_rdata_o,
   // Leaf decision
   input  wire enclave_exit_pkg::leaf_req_t     leaf_req_i,
   output enclave_exit_pkg::leaf_rsp_t          leaf_rsp_o,
   output logic                                 leaf_done_o,
   // Memory access decision
   input  wire enclave_exit_pkg::mem_req_t      mem_req_i,
   output enclave_exit_pkg::mem_rsp_t           mem_rsp_o,
   output logic                                 mem_done_o,
   // Conflict events
   input  wire enclave_exit_pkg::conflict_req_t conflict_req_i,
   output logic                                 conflict_exit_o,
   output logic      [63:0]                     exit_qual_o,
   output logic      [15:0]                     exit_reason_o
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [31:0]                  ctrl;
      logic [31:0]                  sec_ctrl;
      logic [63:0]                  bitmap;
      logic [63:0]                  qual;
      logic [15:0]                  reason;
      logic [31:0]                  rdata;
      logic [7:0]                   exit_count;
      enclave_exit_pkg::leaf_rsp_t  leaf_rsp;
      logic                         leaf_done;
      enclave_exit_pkg::mem_rsp_t   mem_rsp;
      logic                         mem_done;
      logic                         conf_exit;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic exit_en;
   logic apic_virt;
   logic virt_ext;

   assign exit_en   = s_q.ctrl[enclave_exit_pkg::CTRL_EXIT_EN_BIT];
   assign apic_virt = s_q.ctrl[enclave_exit_pkg::CTRL_APIC_VIRT_BIT];
   assign virt_ext  = s_q.sec_ctrl[enclave_exit_pkg::SEC_VIRT_EXT_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic        cpl_ok;
      logic        bit_hit;
      logic        imp_ok;
      logic [15:0] code;
      s_d       = s_q;
      cpl_ok    = 1'b0;
      bit_hit   = 1'b0;
      imp_ok    = 1'b0;
      code      = enclave_exit_pkg::QC_TRACK_RES;

      // Register writes
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            enclave_exit_pkg::OFS_CTRL:      s_d.ctrl = reg_wdata_i;
            enclave_exit_pkg::OFS_BITMAP_LO: s_d.bitmap[31:0] = reg_wdata_i;
            enclave_exit_pkg::OFS_BITMAP_HI: s_d.bitmap[63:32] = reg_wdata_i;
            enclave_exit_pkg::OFS_SEC_CTRL:  s_d.sec_ctrl = reg_wdata_i;
            default: ;
         endcase
      end

      // Register reads, data in the following cycle
      s_d.rdata = 32'h0000_0000;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            enclave_exit_pkg::OFS_CTRL:      s_d.rdata = s_q.ctrl;
            enclave_exit_pkg::OFS_BITMAP_LO: s_d.rdata = s_q.bitmap[31:0];
            enclave_exit_pkg::OFS_BITMAP_HI: s_d.rdata = s_q.bitmap[63:32];
            enclave_exit_pkg::OFS_SEC_CTRL:  s_d.rdata = s_q.sec_ctrl;
            enclave_exit_pkg::OFS_QUAL_LO:   s_d.rdata = s_q.qual[31:0];
            enclave_exit_pkg::OFS_QUAL_HI:   s_d.rdata = s_q.qual[63:32];
            enclave_exit_pkg::OFS_REASON:    s_d.rdata = {16'h0000, s_q.reason};
            enclave_exit_pkg::OFS_STATUS:    s_d.rdata = {24'h000000, s_q.exit_count};
            default:                         s_d.rdata = 32'h0000_0000;
         endcase
      end

      ////////////////////////////////////////////////////////////////////////
      // Privileged / user leaf decision
      s_d.leaf_rsp  = '0;
      s_d.leaf_done = leaf_req_i.valid;
      if (leaf_req_i.valid) begin
         cpl_ok  = (leaf_req_i.current_privilege_level == 2'h0);
         bit_hit = s_q.bitmap[leaf_req_i.leaf];
         if (!leaf_req_i.legal_mode) begin
            s_d.leaf_rsp.fault_ud = 1'b1;
         end else if (leaf_req_i.user_leaf) begin
            // Guest state adds nothing to user leaves
            s_d.leaf_rsp.allow = 1'b1;
         end else if (!cpl_ok) begin
            s_d.leaf_rsp.fault_gp = 1'b1;
         end else if (leaf_req_i.guest && exit_en && bit_hit) begin
            s_d.leaf_rsp.vm_exit = 1'b1;
            s_d.reason           = enclave_exit_pkg::REASON_LEAF;
         end else begin
            s_d.leaf_rsp.allow = 1'b1;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Memory access decision
      s_d.mem_rsp  = '0;
      s_d.mem_done = mem_req_i.valid;
      if (mem_req_i.valid) begin
         // Operand addresses always take both translation stages in the guest
         s_d.mem_rsp.nested_walk = mem_req_i.guest && !(mem_req_i.kind ==
                                   enclave_exit_pkg::ACC_IMPLICIT);
         imp_ok = (mem_req_i.target != enclave_exit_pkg::TGT_OTHER);
         if (!mem_req_i.xlat_ok) begin
            s_d.mem_rsp.fault_vec = enclave_exit_pkg::VEC_PF;
         end else if (mem_req_i.fetch && mem_req_i.in_enclave && !mem_req_i.in_range) begin
            // Checked before any APIC overlap handling
            s_d.mem_rsp.fault_vec = enclave_exit_pkg::VEC_GP;
         end else if (mem_req_i.kind == enclave_exit_pkg::ACC_IMPLICIT) begin
            if (imp_ok) begin
               s_d.mem_rsp.allow = 1'b1;
            end else begin
               s_d.mem_rsp.fault_vec = enclave_exit_pkg::VEC_GP;
            end
         end else if (mem_req_i.guest && apic_virt && mem_req_i.apic_overlap) begin
            if (mem_req_i.kind == enclave_exit_pkg::ACC_EXPLICIT_ENCL) begin
               s_d.mem_rsp.fault_vec = enclave_exit_pkg::VEC_PF;
            end else begin
               s_d.mem_rsp.apic_exit = 1'b1;
               s_d.reason            = enclave_exit_pkg::REASON_APIC;
            end
         end else begin
            s_d.mem_rsp.allow = 1'b1;
         end
         // Flag updates stand even if the instruction later faults elsewhere
         s_d.mem_rsp.set_ad = mem_req_i.guest && mem_req_i.page_store &&
                              (s_d.mem_rsp.fault_vec == enclave_exit_pkg::VEC_NONE) &&
                              !s_d.mem_rsp.apic_exit;
      end

      ////////////////////////////////////////////////////////////////////////
      // Conflict exit; wins over other exit reason updates in the same cycle
      s_d.conf_exit = 1'b0;
      if (conflict_req_i.valid && conflict_req_i.guest && virt_ext) begin
         unique case (conflict_req_i.kind)
            enclave_exit_pkg::CONF_TRACK_RES:  code = enclave_exit_pkg::QC_TRACK_RES;
            enclave_exit_pkg::CONF_TRACK_REF:  code = enclave_exit_pkg::QC_TRACK_REF;
            enclave_exit_pkg::CONF_PAGE_FAULT: code = enclave_exit_pkg::QC_PAGE_FAULT;
            enclave_exit_pkg::CONF_PAGE_ERR:   code = enclave_exit_pkg::QC_PAGE_ERR;
         endcase
         s_d.conf_exit = 1'b1;
         s_d.reason    = enclave_exit_pkg::REASON_CONFLICT;
         s_d.qual      = {32'h0000_0000,
                          (code == enclave_exit_pkg::QC_PAGE_ERR) ? conflict_req_i.err
                                                                  : 16'h0000,
                          code};
         s_d.exit_count = s_q.exit_count + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         s_q        <= '0;
         s_q.ctrl   <= enclave_exit_pkg::CTRL_RESET;
         s_q.bitmap <= enclave_exit_pkg::BITMAP_RESET;
         s_q.reason <= enclave_exit_pkg::REASON_NONE;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o     = s_q.rdata;
   assign leaf_rsp_o      = s_q.leaf_rsp;
   assign leaf_done_o     = s_q.leaf_done;
   assign mem_rsp_o       = s_q.mem_rsp;
   assign mem_done_o      = s_q.mem_done;
   assign conflict_exit_o = s_q.conf_exit;
   assign exit_qual_o     = s_q.qual;
   assign exit_reason_o   = s_q.reason;

endmodule

/* verif/enclave_exit_sva.sv */
// Purpose: Port-level assertions for the enclave guest exit control block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound into every instance of the design top
`timescale 1ns/1ps
module enclave_exit_sva (
   // Clock and reset
   input wire logic                            sys_clk_i,
   input wire logic                            reset_i,
   // Leaf decision
   input wire enclave_exit_pkg::leaf_req_t     leaf_req_i,
   input wire enclave_exit_pkg::leaf_rsp_t     leaf_rsp_o,
   input wire logic                            leaf_done_o,
   // Memory access decision
   input wire enclave_exit_pkg::mem_req_t      mem_req_i,
   input wire enclave_exit_pkg::mem_rsp_t      mem_rsp_o,
   // Conflict events
   input wire enclave_exit_pkg::conflict_req_t conflict_req_i,
   input wire logic                            conflict_exit_o,
   input wire logic [63:0]                     exit_qual_o,
   input wire logic [15:0]                     exit_reason_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////////////////////////
   AST_LEAF_ANSWER: assert property (leaf_req_i.valid |=> leaf_done_o)
      else $error("leaf request not answered in next cycle");
   AST_USER_LEAF: assert property (leaf_req_i.valid && leaf_req_i.legal_mode
      && leaf_req_i.user_leaf |=> leaf_rsp_o.allow && !leaf_rsp_o.vm_exit)
      else $error("user leaf not allowed");
   AST_PRIV_FIRST: assert property (leaf_req_i.valid && leaf_req_i.legal_mode
      && !leaf_req_i.user_leaf && leaf_req_i.current_privilege_level != 2'h0
      |=> leaf_rsp_o.fault_gp && !leaf_rsp_o.vm_exit)
      else $error("privilege check did not win over bitmap");
   AST_LEAF_REASON: assert property (leaf_done_o && leaf_rsp_o.vm_exit && !conflict_exit_o
      |-> exit_reason_o == enclave_exit_pkg::REASON_LEAF)
      else $error("leaf exit without leaf reason");
   AST_IMPLICIT_NO_APIC: assert property (mem_req_i.valid
      && mem_req_i.kind == enclave_exit_pkg::ACC_IMPLICIT
      |=> !mem_rsp_o.apic_exit && !mem_rsp_o.redirect)
      else $error("implicit access took APIC path");
   AST_FETCH_GP: assert property (mem_req_i.valid && mem_req_i.xlat_ok && mem_req_i.fetch
      && mem_req_i.in_enclave && !mem_req_i.in_range
      |=> mem_rsp_o.fault_vec == enclave_exit_pkg::VEC_GP && !mem_rsp_o.apic_exit)
      else $error("out of range fetch not general protection");
   AST_CONF_REASON: assert property (conflict_exit_o
      |-> exit_reason_o == enclave_exit_pkg::REASON_CONFLICT && exit_qual_o[63:32] == 32'h0)
      else $error("conflict exit reason or upper qualification wrong");
   AST_CONF_QUAL: assert property (conflict_exit_o
      |-> exit_qual_o[15:0] == {14'h0, $past(conflict_req_i.kind)}
      && exit_qual_o[31:16] == (($past(conflict_req_i.kind) == enclave_exit_pkg::CONF_PAGE_ERR)
      ? $past(conflict_req_i.err) : 16'h0000))
      else $error("conflict qualification code or error wrong");
   // Skip the first edge after reset, the qualification was cleared under it
   AST_QUAL_HOLD: assert property (!conflict_exit_o && !$past(reset_i)
      |-> $stable(exit_qual_o))
      else $error("qualification changed without a conflict exit");
endmodule
bind enclave_guest_exit_control enclave_exit_sva i_enclave_exit_sva (.sys_clk_i(sys_clk_i),
   .reset_i(reset_i), .leaf_req_i(leaf_req_i), .leaf_rsp_o(leaf_rsp_o), .leaf_done_o(leaf_done_o),
   .mem_req_i(mem_req_i), .mem_rsp_o(mem_rsp_o), .conflict_req_i(conflict_req_i),
   .conflict_exit_o(conflict_exit_o), .exit_qual_o(exit_qual_o), .exit_reason_o(exit_reason_o));

/* verif/testbench.sv */
// Purpose: Directed self-checking bench for the enclave guest exit control block
// Assumes: Register reads answer one cycle after the strobe
// Notes:   Memory cases are swept exhaustively over their request fields; leaf cases sweep the leaf number and the mode bits separately
`timescale 1ns/1ps
module testbench;
   logic                            sys_clk_i = 1'b0;
   logic                            reset_i = 1'b1;
   logic [7:0]                      reg_addr_i = 8'h00;
   logic [31:0]                     reg_wdata_i = 32'h0000_0000;
   logic                            reg_wr_i = 1'b0;
   logic                            reg_rd_i = 1'b0;
   logic [31:0]                     reg_rdata_o;
   enclave_exit_pkg::leaf_req_t     leaf_req_i = '0;
   enclave_exit_pkg::leaf_rsp_t     leaf_rsp_o;
   logic                            leaf_done_o;
   enclave_exit_pkg::mem_req_t      mem_req_i = '0;
   enclave_exit_pkg::mem_rsp_t      mem_rsp_o;
   logic                            mem_done_o;
   enclave_exit_pkg::conflict_req_t conflict_req_i = '0;
   logic                            conflict_exit_o;
   logic [63:0]                     exit_qual_o;
   logic [15:0]                     exit_reason_o;
   int                              bad_count = 0;
   int                              n_checks = 0;
   // Bench copy of what software has programmed, and of the last exit
   logic [63:0]                     bmap = 64'h0;
   logic                            en = 1'b0;
   logic                            av = 1'b0;
   logic                            ext = 1'b0;
   logic [63:0]                     e_qual = 64'h0;
   logic [15:0]                     e_reason = 16'h0000;

   always #2.5 sys_clk_i = ~sys_clk_i;

   enclave_guest_exit_control i_enclave_guest_exit_control (.sys_clk_i(sys_clk_i),
      .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .leaf_req_i(leaf_req_i), .leaf_rsp_o(leaf_rsp_o), .leaf_done_o(leaf_done_o),
      .mem_req_i(mem_req_i), .mem_rsp_o(mem_rsp_o), .mem_done_o(mem_done_o),
      .conflict_req_i(conflict_req_i), .conflict_exit_o(conflict_exit_o),
      .exit_qual_o(exit_qual_o), .exit_reason_o(exit_reason_o));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 check("reg_rdata_o", 64'(exp), 64'(reg_rdata_o));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic leaf_op(input enclave_exit_pkg::leaf_req_t q);
      enclave_exit_pkg::leaf_rsp_t r;
      r = '0;
      if (!q.legal_mode) r.fault_ud = 1'b1;
      else if (q.user_leaf) r.allow = 1'b1;
      else if (q.current_privilege_level != 2'h0) r.fault_gp = 1'b1;
      else if (q.guest && en && bmap[q.leaf]) r.vm_exit = 1'b1;
      else r.allow = 1'b1;
      if (r.vm_exit) e_reason = enclave_exit_pkg::REASON_LEAF;
      @(posedge sys_clk_i);
      leaf_req_i <= q;
      @(posedge sys_clk_i);
      leaf_req_i <= '0;
      #1 check("leaf_done_o", 64'h1, 64'(leaf_done_o));
      check("leaf_rsp_o", 64'(r), 64'(leaf_rsp_o));
      check("exit_reason_o", 64'(e_reason), 64'(exit_reason_o));
   endtask

   task automatic mem_op(input enclave_exit_pkg::mem_req_t q);
      enclave_exit_pkg::mem_rsp_t r;
      r = '0;
      if (!q.xlat_ok) r.fault_vec = enclave_exit_pkg::VEC_PF;
      else if (q.fetch && q.in_enclave && !q.in_range) r.fault_vec = enclave_exit_pkg::VEC_GP;
      else if (q.kind == enclave_exit_pkg::ACC_IMPLICIT) begin
         if (q.target == enclave_exit_pkg::TGT_OTHER) r.fault_vec = enclave_exit_pkg::VEC_GP;
      end else if (q.guest && av && q.apic_overlap) begin
         if (q.kind == enclave_exit_pkg::ACC_NON_ENCLAVE) r.apic_exit = 1'b1;
         else r.fault_vec = enclave_exit_pkg::VEC_PF;
      end
      r.allow = r.fault_vec == enclave_exit_pkg::VEC_NONE && !r.apic_exit;
      r.set_ad = q.guest && q.page_store && r.allow;
      r.nested_walk = q.guest && q.kind != enclave_exit_pkg::ACC_IMPLICIT;
      if (r.apic_exit) e_reason = enclave_exit_pkg::REASON_APIC;
      @(posedge sys_clk_i);
      mem_req_i <= q;
      @(posedge sys_clk_i);
      mem_req_i <= '0;
      #1 check("mem_done_o", 64'h1, 64'(mem_done_o));
      check("mem_rsp_o", 64'(r), 64'(mem_rsp_o));
      check("exit_reason_o", 64'(e_reason), 64'(exit_reason_o));
   endtask

   task automatic conf_op(input logic g, input logic [1:0] k);
      enclave_exit_pkg::conflict_req_t q;
      logic hit;
      q = {1'b1, g, k, 16'hA5C3};
      hit = g && ext;
      if (hit) begin
         e_qual = {32'h0, (k == 2'h3) ? q.err : 16'h0000, 14'h0, k};
         e_reason = enclave_exit_pkg::REASON_CONFLICT;
      end
      @(posedge sys_clk_i);
      conflict_req_i <= q;
      @(posedge sys_clk_i);
      conflict_req_i <= '0;
      #1 check("conflict_exit_o", 64'(hit), 64'(conflict_exit_o));
      check("exit_qual_o", e_qual, exit_qual_o);
      check("exit_reason_o", 64'(e_reason), 64'(exit_reason_o));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      // All registers clear at reset; 0x20 is unmapped
      for (int a = 0; a <= 32; a += 4) reg_read(8'(a), 32'h0);
      bmap = 64'h8000_0000_0000_0021;
      reg_write(enclave_exit_pkg::OFS_BITMAP_LO, bmap[31:0]);
      reg_write(enclave_exit_pkg::OFS_BITMAP_HI, bmap[63:32]);
      reg_read(enclave_exit_pkg::OFS_BITMAP_LO, bmap[31:0]);
      reg_read(enclave_exit_pkg::OFS_BITMAP_HI, bmap[63:32]);
      reg_write(enclave_exit_pkg::OFS_QUAL_LO, 32'hFFFF_FFFF);
      reg_read(enclave_exit_pkg::OFS_QUAL_LO, 32'h0);
      for (int e = 0; e < 2; e++) begin
         en = e[0];
         reg_write(enclave_exit_pkg::OFS_CTRL, {31'h0, en});
         for (int l = 0; l < 64; l++) leaf_op({4'b1110, 2'h0, l[5:0]});
      end
      for (int j = 0; j < 32; j++) leaf_op({1'b1, j[4:0], 6'h00});
      for (int v = 0; v < 2; v++) begin
         av = v[0];
         reg_write(enclave_exit_pkg::OFS_CTRL, {30'h0, av, en});
         for (int i = 0; i < 2048; i++)
            if (i[9:8] != 2'h2) mem_op({1'b1, i[10:0]});
      end
      conf_op(1'b1, 2'h3);
      reg_write(enclave_exit_pkg::OFS_SEC_CTRL, 32'h2000_0000);
      ext = 1'b1;
      for (int k = 0; k < 4; k++) conf_op(1'b1, k[1:0]);
      conf_op(1'b0, 2'h1);
      leaf_op({4'b1110, 2'h0, 6'h05});
      reg_read(enclave_exit_pkg::OFS_QUAL_LO, e_qual[31:0]);
      reg_read(enclave_exit_pkg::OFS_QUAL_HI, 32'h0);
      reg_read(enclave_exit_pkg::OFS_REASON, {16'h0, e_reason});
      reg_read(enclave_exit_pkg::OFS_STATUS, 32'h4);
      report_and_stop;
   end

   // About 6500 cycles expected; over four times that means a hang
   initial begin
      repeat (30000) @(posedge sys_clk_i);
      bad_count++;
      report_and_stop;
   end
endmodule
